// ### core/rxpp_top.sv
// Receive frame pre-processing: filtering stages, early flags, acceptance,
// end-of-frame events and one held frame in on-chip RAM with commit and release.
// Assumes the MAC stream and register port are on CLK; DA filter result comes with the stream.
`timescale 1ns/1ps
module rxpp_top #(
	parameter int AW      = 10,
	parameter int CNT_W   = 10
) (
	input  wire logic                   CLK,
	input  wire logic                   NRST,
	input  wire rxpp_pkg::rxpp_rx_t      RX,
	input  wire rxpp_pkg::rxpp_reg_req_t REG,
	output logic                [15:0]  REG_RDATA,
	input  wire logic                   HOST_DATA_RD,
	output logic                [15:0]  HOST_DATA,
	input  wire logic                   DMA_FRAMES_DONE,
	output rxpp_pkg::rxpp_dma_t          DMA,
	output rxpp_pkg::rxpp_cfg_t          CFG,
	output logic                        IRQ
);
	typedef enum logic [1:0] {H_IDLE, H_FILL, H_HELD} rxpp_hold_t;

	typedef struct packed {
		logic [15:0]      rx_cfg;
		logic [15:0]      rx_ctl;
		logic [15:0]      buf_cfg;
		logic [15:0]      bus_ctl;
		logic [15:0]      rx_evt;
		logic [15:0]      buf_evt;
		rxpp_hold_t       hold;
		logic             committed;
		logic             in_frame;
		logic             to_dma;
		logic             dropped;
		logic             da_passed;
		logic             early_seen;
		logic             foreign_evt;
		logic [10:0]      byte_cnt;
		logic [10:0]      frame_len;
		logic [7:0]       lo_byte;
		logic [AW-1:0]    wr_ptr;
		logic [AW-1:0]    rd_ptr;
		logic [CNT_W-1:0] lost_cnt;
		logic [10:0]      hold_cnt;
		logic [15:0]      rdata;
		logic             mem_we;
		logic [AW-1:0]    mem_wa;
		logic [15:0]      mem_wd;
		rxpp_pkg::rxpp_dma_t dma;
	} rxpp_state_t;

	rxpp_state_t s_reg;
	rxpp_state_t s_next;

	logic        runt;
	logic        too_long;
	logic        good;
	logic        accept;
	logic [10:0] len_words;
	logic        lost_evt;

	// Frame classification at end of frame
	always_comb begin
		runt      = s_reg.byte_cnt < rxpp_pkg::MIN_FRAME;
		too_long  = s_reg.byte_cnt > rxpp_pkg::MAX_STORE;
		good      = !RX.crc_bad && !runt && !too_long;
		accept    = s_reg.rx_ctl[rxpp_pkg::RXA_ALL] ||
			(s_reg.da_passed && ((good && s_reg.rx_ctl[rxpp_pkg::RXA_GOOD]) ||
			(RX.crc_bad && s_reg.rx_ctl[rxpp_pkg::RXA_CRC]) ||
			(runt && s_reg.rx_ctl[rxpp_pkg::RXA_RUNT]) ||
			(too_long && s_reg.rx_ctl[rxpp_pkg::RXA_LONG])));
		len_words = (s_reg.frame_len + 11'd1) >> 1;
	end

	// Register access first, frame events after, so a set in the same cycle wins
	always_comb begin
		s_next            = s_reg;
		s_next.mem_we     = 1'b0;
		s_next.dma.valid  = 1'b0;
		s_next.dma.abort  = 1'b0;
		s_next.dma.bus_release = 1'b0;
		lost_evt          = 1'b0;

		// Register writes
		if (REG.wr) begin
			case (REG.num)
				rxpp_pkg::REG_RX_CFG: begin
					s_next.rx_cfg = REG.wdata & ~(16'h0001 << rxpp_pkg::RXC_DISCARD);
					if (REG.wdata[rxpp_pkg::RXC_DISCARD] && s_reg.committed) begin
						s_next.committed = 1'b0;
						s_next.hold      = (s_reg.hold == H_FILL) ? H_FILL : H_IDLE;
						s_next.dropped   = (s_reg.hold == H_FILL);
					end
				end
				rxpp_pkg::REG_RX_CTL:  s_next.rx_ctl  = REG.wdata;
				rxpp_pkg::REG_BUF_CFG: s_next.buf_cfg = REG.wdata;
				rxpp_pkg::REG_BUS_CTL: s_next.bus_ctl = REG.wdata;
				default: ;
			endcase
		end

		// Register reads; event reads clear their flags and may commit or release
		if (REG.rd) begin
			s_next.rdata = 16'h0000;
			case (REG.num)
				rxpp_pkg::REG_RX_CFG:  s_next.rdata = s_reg.rx_cfg;
				rxpp_pkg::REG_RX_CTL:  s_next.rdata = s_reg.rx_ctl;
				rxpp_pkg::REG_BUF_CFG: s_next.rdata = s_reg.buf_cfg;
				rxpp_pkg::REG_BUS_CTL: s_next.rdata = s_reg.bus_ctl;
				rxpp_pkg::REG_RX_EVT:  s_next.rdata = s_reg.rx_evt;
				rxpp_pkg::REG_BUF_EVT: s_next.rdata = s_reg.buf_evt;
				rxpp_pkg::REG_EVT_QUEUE: begin
					s_next.rdata = (s_reg.rx_evt != 16'h0000) ? s_reg.rx_evt : s_reg.buf_evt;
				end
				default: ;
			endcase
			if (REG.num == rxpp_pkg::REG_RX_EVT ||
					(REG.num == rxpp_pkg::REG_EVT_QUEUE && s_reg.rx_evt != 16'h0000)) begin
				s_next.rx_evt = 16'h0000;
				if (s_reg.hold == H_HELD && !s_reg.committed) begin
					s_next.committed = 1'b1;
				end
				if (s_reg.committed && s_reg.foreign_evt && s_reg.rx_evt != 16'h0000) begin
					s_next.committed = 1'b0;
					s_next.hold      = (s_reg.hold == H_FILL) ? H_FILL : H_IDLE;
					s_next.dropped   = (s_reg.hold == H_FILL);
				end
			end else if (REG.num == rxpp_pkg::REG_BUF_EVT || REG.num == rxpp_pkg::REG_EVT_QUEUE) begin
				s_next.buf_evt = 16'h0000;
				if (s_reg.hold == H_FILL && s_reg.early_seen && !s_reg.dropped) begin
					s_next.committed = 1'b1;
				end
			end
		end

		// Host data read port; released once the last word of a committed complete frame is read
		if (HOST_DATA_RD && s_reg.hold != H_IDLE) begin
			s_next.rd_ptr = s_reg.rd_ptr + AW'(1);
			if (s_reg.committed && s_reg.hold == H_HELD &&
					{{(11-AW){1'b0}}, s_reg.rd_ptr} + 11'd1 >= len_words) begin
				s_next.committed = 1'b0;
				s_next.hold      = H_IDLE;
			end
		end

		// DMA completion from the DMA engine
		if (DMA_FRAMES_DONE) begin
			s_next.buf_evt[rxpp_pkg::BUF_DMA_DONE] = 1'b1;
		end

		// Start of frame: choose on-chip or DMA, or lose it when space is committed
		if (RX.sof) begin
			s_next.in_frame   = 1'b1;
			s_next.byte_cnt   = 11'd0;
			s_next.da_passed  = 1'b0;
			s_next.hold_cnt   = 11'd0;
			s_next.to_dma     = s_reg.rx_cfg[rxpp_pkg::RXC_DMA_ONLY] ||
				(s_reg.rx_cfg[rxpp_pkg::RXC_AUTO_DMA] && s_reg.committed);
			s_next.dropped    = 1'b0;
			if (!s_next.to_dma && s_reg.committed) begin
				s_next.dropped = 1'b1;
				lost_evt       = 1'b1;
			end else if (!s_next.to_dma) begin
				// An uncommitted held frame may be overwritten
				s_next.hold        = H_FILL;
				s_next.wr_ptr      = '0;
				s_next.rd_ptr      = '0;
				s_next.early_seen  = 1'b0;
				s_next.foreign_evt = 1'b0;
			end
		end

		// Lost frame bookkeeping
		if (lost_evt) begin
			s_next.buf_evt[rxpp_pkg::BUF_LOST] = 1'b1;
			s_next.lost_cnt = s_reg.lost_cnt + CNT_W'(1);
			if (&s_reg.lost_cnt) begin
				s_next.buf_evt[rxpp_pkg::BUF_LOST_WRAP] = 1'b1;
			end
		end

		// Stage one: destination address filter result
		if (s_reg.in_frame && RX.da_done) begin
			if (RX.da_ok) begin
				s_next.da_passed = 1'b1;
				if (!s_reg.committed && !s_reg.dropped) begin
					s_next.buf_evt[rxpp_pkg::BUF_EARLY_ADR] = 1'b1;
					s_next.early_seen = !s_reg.to_dma;
				end
			end else begin
				s_next.in_frame = 1'b0;
				s_next.dma.abort = s_reg.to_dma;
				if (!s_reg.to_dma && !s_reg.dropped) begin
					s_next.hold = H_IDLE;
				end
			end
		end

		// Data bytes: count, pair into words low byte first, or pass to DMA
		if (s_reg.in_frame && RX.valid && !s_reg.dropped && !(RX.da_done && !RX.da_ok)) begin
			if (s_reg.byte_cnt != 11'h7ff) begin
				s_next.byte_cnt = s_reg.byte_cnt + 11'd1;
			end
			if (s_reg.byte_cnt < rxpp_pkg::MAX_STORE) begin
				if (s_reg.to_dma) begin
					s_next.dma.valid = 1'b1;
					s_next.dma.data  = RX.data;
				end else if (!s_reg.byte_cnt[0]) begin
					s_next.lo_byte = RX.data;
				end else begin
					s_next.mem_we = 1'b1;
					s_next.mem_wa = s_reg.wr_ptr;
					s_next.mem_wd = {RX.data, s_reg.lo_byte};
					s_next.wr_ptr = s_reg.wr_ptr + AW'(1);
				end
			end
			if (s_reg.byte_cnt == rxpp_pkg::EARLY_BLOCK - 11'd1 && !s_reg.committed) begin
				s_next.buf_evt[rxpp_pkg::BUF_EARLY_BLK] = 1'b1;
				s_next.buf_evt[rxpp_pkg::BUF_EARLY_ADR] = 1'b0;
				s_next.early_seen = !s_reg.to_dma;
			end
		end

		// DMA bus hold limit, counted while a DMA frame streams
		if (s_reg.in_frame && s_reg.to_dma && s_reg.bus_ctl[rxpp_pkg::BUS_HOLD_LIM]) begin
			s_next.hold_cnt = s_reg.hold_cnt + 11'd1;
			if (s_reg.hold_cnt == rxpp_pkg::DMA_HOLD_CYC - 11'd1) begin
				s_next.dma.bus_release = 1'b1;
				s_next.hold_cnt        = 11'd0;
			end
		end

		// End of frame: acceptance, events, hand the frame to the host
		if (s_reg.in_frame && RX.eof) begin
			s_next.in_frame = 1'b0;
			s_next.buf_evt[rxpp_pkg::BUF_EARLY_BLK] = 1'b0;
			if (accept && !s_reg.dropped) begin
				s_next.rx_evt[rxpp_pkg::RXE_GOOD] = s_next.rx_evt[rxpp_pkg::RXE_GOOD] | good;
				s_next.rx_evt[rxpp_pkg::RXE_CRC]  = s_next.rx_evt[rxpp_pkg::RXE_CRC] | RX.crc_bad;
				s_next.rx_evt[rxpp_pkg::RXE_RUNT] = s_next.rx_evt[rxpp_pkg::RXE_RUNT] | runt;
				s_next.rx_evt[rxpp_pkg::RXE_LONG] = s_next.rx_evt[rxpp_pkg::RXE_LONG] | too_long;
				if (s_reg.committed && s_reg.hold != H_FILL) begin
					s_next.foreign_evt = 1'b1;
				end
			end
			if (!s_reg.to_dma && !s_reg.dropped) begin
				// Odd last byte goes out alone
				if (s_reg.byte_cnt[0] && s_reg.byte_cnt <= rxpp_pkg::MAX_STORE) begin
					s_next.mem_we = 1'b1;
					s_next.mem_wa = s_reg.wr_ptr;
					s_next.mem_wd = {8'h00, s_reg.lo_byte};
				end
				s_next.frame_len = (s_reg.byte_cnt > rxpp_pkg::MAX_STORE) ? rxpp_pkg::MAX_STORE : s_reg.byte_cnt;
				if (!s_reg.rx_cfg[rxpp_pkg::RXC_KEEP_FCS]) begin
					// Check sequence stays in RAM but is cut from the length
					s_next.frame_len = (s_next.frame_len > rxpp_pkg::FCS_BYTES) ?
						s_next.frame_len - rxpp_pkg::FCS_BYTES : 11'd0;
				end
				if (accept || s_reg.committed) begin
					s_next.hold = H_HELD;
				end else begin
					s_next.hold = H_IDLE;
				end
			end
		end
	end

	// Single state register
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			s_reg         <= '0;
			s_reg.rx_cfg  <= rxpp_pkg::RX_CFG_RST;
			s_reg.rx_ctl  <= rxpp_pkg::RX_CTL_RST;
			s_reg.buf_cfg <= rxpp_pkg::BUF_CFG_RST;
			s_reg.bus_ctl <= rxpp_pkg::BUS_CTL_RST;
			s_reg.hold    <= H_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	rxpp_ram #(
		.AW (AW),
		.DW (16)
	) u_ram (
		.clk   (CLK),
		.we    (s_reg.mem_we),
		.waddr (s_reg.mem_wa),
		.wdata (s_reg.mem_wd),
		.raddr (s_reg.rd_ptr),
		.rdata (HOST_DATA)
	);

	// Outputs; early interrupts masked while a committed frame waits
	assign REG_RDATA = s_reg.rdata;
	assign DMA       = s_reg.dma;
	assign IRQ = |(s_reg.rx_evt & s_reg.rx_cfg & rxpp_pkg::RXE_IE_MASK) |
		|(s_reg.buf_evt & s_reg.buf_cfg & rxpp_pkg::BUF_IE_MASK &
		~(s_reg.committed ? rxpp_pkg::BUF_EARLY_MSK : 16'h0000));
	assign CFG.continuous_transfer_en = s_reg.rx_cfg[rxpp_pkg::RXC_STREAM];
	assign CFG.force_dma_all_frames   = s_reg.rx_cfg[rxpp_pkg::RXC_DMA_ONLY];
	assign CFG.auto_switch_dma_en     = s_reg.rx_cfg[rxpp_pkg::RXC_AUTO_DMA];
	assign CFG.keep_fcs_en            = s_reg.rx_cfg[rxpp_pkg::RXC_KEEP_FCS];
	assign CFG.dma_bus_hold_limit     = s_reg.bus_ctl[rxpp_pkg::BUS_HOLD_LIM];
	assign CFG.dma_buffer_size_sel    = s_reg.bus_ctl[rxpp_pkg::BUS_DMA_64K];

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!NRST);

	sequence s_lost_start;
		RX.sof && !REG.rd && s_reg.committed && !s_reg.rx_cfg[rxpp_pkg::RXC_DMA_ONLY] &&
			!s_reg.rx_cfg[rxpp_pkg::RXC_AUTO_DMA];
	endsequence
	property p_lost_flag;
		s_lost_start |=> s_reg.buf_evt[rxpp_pkg::BUF_LOST] && s_reg.dropped;
	endproperty
	a_lost_flag: assert property (p_lost_flag) else $error("lost frame not flagged");

	property p_dma_irq;
		DMA_FRAMES_DONE && s_reg.buf_cfg[rxpp_pkg::BUF_DMA_DONE] |=> IRQ;
	endproperty
	a_dma_irq: assert property (p_dma_irq) else $error("dma done interrupt missing");

	property p_block_clears_addr;
		$rose(s_reg.buf_evt[rxpp_pkg::BUF_EARLY_BLK]) |-> !s_reg.buf_evt[rxpp_pkg::BUF_EARLY_ADR];
	endproperty
	a_block_clears_addr: assert property (p_block_clears_addr) else $error("address flag kept");

	property p_da_fail_drop;
		s_reg.in_frame && RX.da_done && !RX.da_ok && !RX.sof |=>
			!s_reg.in_frame && !$rose(s_reg.buf_evt[rxpp_pkg::BUF_EARLY_ADR]);
	endproperty
	a_da_fail_drop: assert property (p_da_fail_drop) else $error("failed frame kept");

	property p_no_early_when_committed;
		s_reg.committed && !REG.wr && !REG.rd && !HOST_DATA_RD |=>
			!$rose(s_reg.buf_evt[rxpp_pkg::BUF_EARLY_ADR]) && !$rose(s_reg.buf_evt[rxpp_pkg::BUF_EARLY_BLK]);
	endproperty
	a_no_early_when_committed: assert property (p_no_early_when_committed) else $error("early flag set");

	property p_discard;
		REG.wr && REG.num == rxpp_pkg::REG_RX_CFG && REG.wdata[rxpp_pkg::RXC_DISCARD] |=>
			!s_reg.committed && !s_reg.rx_cfg[rxpp_pkg::RXC_DISCARD];
	endproperty
	a_discard: assert property (p_discard) else $error("discard did not release");

	property p_lost_no_write;
		s_reg.dropped && s_reg.in_frame && !RX.sof |=> !s_reg.mem_we;
	endproperty
	a_lost_no_write: assert property (p_lost_no_write) else $error("write into committed space");

	sequence s_eof_good;
		s_reg.in_frame && RX.eof && !s_reg.dropped && !RX.crc_bad &&
			s_reg.byte_cnt >= rxpp_pkg::MIN_FRAME && s_reg.byte_cnt <= rxpp_pkg::MAX_STORE;
	endsequence
	property p_good_event;
		s_eof_good ##0 (s_reg.da_passed && s_reg.rx_ctl[rxpp_pkg::RXA_GOOD] &&
			s_reg.rx_cfg[rxpp_pkg::RXC_GOOD_IE]) |=> s_reg.rx_evt[rxpp_pkg::RXE_GOOD] && IRQ;
	endproperty
	a_good_event: assert property (p_good_event) else $error("good frame event missing");

	property p_wrap;
		lost_evt && (&s_reg.lost_cnt) |=> s_reg.buf_evt[rxpp_pkg::BUF_LOST_WRAP] && s_reg.lost_cnt == '0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter wrap not flagged");
endmodule // rxpp_top

// ### include/rxpp_pkg.sv
// Package for the receive pre-processing and held-frame buffer.
// Assumes one 50 MHz clock; register numbers are word indexes on the register port.
package rxpp_pkg;

	// Register numbers as seen on the register port
	localparam logic [5:0] REG_RX_CFG    = 6'h03;
	localparam logic [5:0] REG_RX_EVT    = 6'h04;
	localparam logic [5:0] REG_RX_CTL    = 6'h05;
	localparam logic [5:0] REG_BUF_CFG   = 6'h0b;
	localparam logic [5:0] REG_BUF_EVT   = 6'h0c;
	localparam logic [5:0] REG_BUS_CTL   = 6'h17;
	localparam logic [5:0] REG_EVT_QUEUE = 6'h20;

	// Reset values of the writable registers
	localparam logic [15:0] RX_CFG_RST  = 16'h0000;
	localparam logic [15:0] RX_CTL_RST  = 16'h0000;
	localparam logic [15:0] BUF_CFG_RST = 16'h0000;
	localparam logic [15:0] BUS_CTL_RST = 16'h0000;

	// receive_config fields
	localparam int RXC_DISCARD   = 6;
	localparam int RXC_STREAM    = 7;
	localparam int RXC_GOOD_IE   = 8;
	localparam int RXC_DMA_ONLY  = 9;
	localparam int RXC_AUTO_DMA  = 10;
	localparam int RXC_KEEP_FCS  = 11;
	localparam int RXC_CRC_IE    = 12;
	localparam int RXC_RUNT_IE   = 13;
	localparam int RXC_LONG_IE   = 14;

	// receive_accept_control fields
	localparam int RXA_ALL       = 7;
	localparam int RXA_GOOD      = 8;
	localparam int RXA_CRC       = 12;
	localparam int RXA_RUNT      = 13;
	localparam int RXA_LONG      = 14;

	// receive_event_status fields share the positions of their enables
	localparam int RXE_GOOD      = 8;
	localparam int RXE_CRC       = 12;
	localparam int RXE_RUNT      = 13;
	localparam int RXE_LONG      = 14;
	localparam logic [15:0] RXE_IE_MASK = 16'h7100;

	// buffer_interrupt_config and buffer_event_flags share positions
	localparam int BUF_DMA_DONE  = 7;
	localparam int BUF_LOST      = 10;
	localparam int BUF_EARLY_BLK = 11;
	localparam int BUF_LOST_WRAP = 13;
	localparam int BUF_EARLY_ADR = 15;
	localparam logic [15:0] BUF_IE_MASK   = 16'hac80;
	localparam logic [15:0] BUF_EARLY_MSK = 16'h8800;

	// bus_control fields
	localparam int BUS_HOLD_LIM  = 11;
	localparam int BUS_DMA_64K   = 13;

	// Frame length landmarks in bytes
	localparam logic [10:0] MAX_STORE   = 11'd1518;
	localparam logic [10:0] MIN_FRAME   = 11'd64;
	localparam logic [10:0] EARLY_BLOCK = 11'd128;
	localparam logic [10:0] FCS_BYTES   = 11'd4;

	// DMA bus hold limit
	localparam int CLK_PERIOD_NS = 20;
	localparam int DMA_HOLD_NS   = 28000;
	localparam logic [10:0] DMA_HOLD_CYC = 11'(DMA_HOLD_NS / CLK_PERIOD_NS);

	// Byte stream from the receive MAC and address filter
	typedef struct packed {
		logic       sof;
		logic       valid;
		logic [7:0] data;
		logic       da_done;
		logic       da_ok;
		logic       eof;
		logic       crc_bad;
	} rxpp_rx_t;

	// Register port request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [5:0]  num;
		logic [15:0] wdata;
	} rxpp_reg_req_t;

	// Transfer-mode settings for the DMA and host logic
	typedef struct packed {
		logic continuous_transfer_en;
		logic force_dma_all_frames;
		logic auto_switch_dma_en;
		logic keep_fcs_en;
		logic dma_bus_hold_limit;
		logic dma_buffer_size_sel;
	} rxpp_cfg_t;

	// Byte stream towards the DMA engine
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       abort;
		logic       bus_release;
	} rxpp_dma_t;

endpackage

// ### core/rxpp_ram.sv
// Word memory holding the frame currently buffered on chip.
// Assumes one clock; read data come out of a register one cycle after the address.
`timescale 1ns/1ps
module rxpp_ram #(
	parameter int AW = 10,
	parameter int DW = 16
) (
	input  wire logic          clk,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// No reset on the array; content is only read after being written
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // rxpp_ram

// ### dv/rxpp_host.sv
// Host processor model: register accesses and held-frame data reads.
// Assumes the bench calls its tasks; requests change 1 ns after CLK rises.
`timescale 1ns/1ps
module rxpp_host (
	input  wire logic                    CLK,
	input  wire logic [15:0]             RDATA,
	input  wire logic [15:0]             HDATA,
	output rxpp_pkg::rxpp_reg_req_t      REG,
	output logic                         DRD
);
	// Idle from time zero
	initial begin
		REG = '0;
		DRD = 1'b0;
	end

	// One access held for one edge; read data taken after that edge
	task automatic acc(input logic w, input logic [5:0] n, input logic [15:0] d, output logic [15:0] q);
		@(posedge CLK) #1;
		REG = '{wr: w, rd: !w, num: n, wdata: d};
		@(posedge CLK) #1;
		q = RDATA;
		REG = '0;
	endtask

	// Word at the pointer, then advance; spacing keeps the next word fresh
	task automatic word(output logic [15:0] q);
		@(posedge CLK) #1;
		q = HDATA;
		DRD = 1'b1;
		@(posedge CLK) #1;
		DRD = 1'b0;
	endtask

	// Release by command only, never by an implied release
	task automatic skip(input logic [15:0] cfg);
		logic [15:0] q;
		acc(1'b1, 6'h03, cfg | 16'h0040, q);
	endtask
endmodule // rxpp_host

// ### dv/tb_rx_frame_preprocess_buffer.sv
// Bench for the receive pre-processing block: frames in, host reads out.
// Assumes the register and stream timing of the design; frame byte i carries value i.
`timescale 1ns/1ps
module tb_rx_frame_preprocess_buffer;
	logic                    CLK, NRST, DFD, HRD, IRQ;
	rxpp_pkg::rxpp_rx_t      RX;
	rxpp_pkg::rxpp_reg_req_t REG;
	rxpp_pkg::rxpp_dma_t     DMA;
	rxpp_pkg::rxpp_cfg_t     CFG;
	logic [15:0]             RDATA, HDATA, q;
	int                      num_errors, checks, nb;
	int                      dma_n, rel_n, abort_n;
	logic [7:0]              dma_last;
	logic [5:0]              rn[5] = '{6'h03, 6'h05, 6'h0b, 6'h17, 6'h3f};
	int                      kl[4] = '{64, 64, 20, 1520};
	logic [15:0]             kb[4] = '{16'h0100, 16'h1000, 16'h2000, 16'h4000};

	rxpp_top DUT (.CLK(CLK), .NRST(NRST), .RX(RX), .REG(REG), .REG_RDATA(RDATA), .HOST_DATA_RD(HRD),
		.HOST_DATA(HDATA), .DMA_FRAMES_DONE(DFD), .DMA(DMA), .CFG(CFG), .IRQ(IRQ));
	rxpp_host H (.CLK(CLK), .RDATA(RDATA), .HDATA(HDATA), .REG(REG), .DRD(HRD));

	// 50 MHz
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end

	// DMA side counts; sampled on the falling edge, where the registered outputs have settled
	always @(negedge CLK) begin
		if (DMA.valid) begin
			dma_n++;
			dma_last = DMA.data;
		end
		if (DMA.bus_release)
			rel_n++;
		if (DMA.abort)
			abort_n++;
	end

	// Reports
	task automatic cmp(input logic [15:0] g, e, input string m);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic cmp_irq(input logic e);
		@(posedge CLK) #1;
		cmp({15'h0, IRQ}, {15'h0, e}, "irq");
	endtask
	task automatic give_verdict;
		$display("mismatches %0d comparisons %0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Register shortcuts
	task automatic rd(input logic [5:0] n, input logic [15:0] e, input string m);
		H.acc(1'b0, n, 16'h0, q);
		cmp(q, e, m);
	endtask
	task automatic wr(input logic [5:0] n, input logic [15:0] d);
		H.acc(1'b1, n, d, q);
	endtask

	// Frame stream; the filter verdict rides with the sixth byte
	task automatic rx_bytes(input int n, input logic ok);
		repeat (n) begin
			@(posedge CLK) #1 RX = '{valid: 1'b1, data: nb[7:0], da_done: nb == 5, da_ok: ok, default: '0};
			nb++;
		end
		@(posedge CLK) #1 RX = '0;
	endtask
	task automatic rx_start(input int n, input logic ok);
		@(posedge CLK) #1 RX = '{sof: 1'b1, default: '0};
		nb = 0;
		rx_bytes(n, ok);
	endtask
	task automatic rx_eof(input logic b);
		@(posedge CLK) #1 RX = '{eof: 1'b1, crc_bad: b, default: '0};
		@(posedge CLK) #1 RX = '0;
	endtask
	task automatic frame(input int n);
		rx_start(n, 1'b1);
		rx_eof(1'b0);
	endtask

	// Hang guard
	initial begin
		#1000000;
		num_errors++;
		give_verdict();
	end

	initial begin
		RX = '0;
		DFD = 1'b0;
		NRST = 1'b0;
		repeat (5) @(posedge CLK);
		#1 NRST = 1'b1;
		// Reset values, unmapped number reads zero
		foreach (rn[k]) rd(rn[k], 16'h0000, "reset");
		wr(6'h03, 16'h0ec0);
		rd(6'h03, 16'h0e80, "rx cfg");
		wr(6'h17, 16'h2800);
		cmp({10'h0, CFG}, 16'h003f, "cfg out");
		wr(6'h17, 16'h0000);
		$display("config done");
		// Each accepted kind, its event and its interrupt
		foreach (kl[k]) begin
			wr(6'h05, kb[k]);
			wr(6'h03, kb[k]);
			rx_start(kl[k], 1'b1);
			cmp_irq(1'b0);
			rx_eof(k == 1);
			cmp_irq(1'b1);
			rd(6'h04, kb[k], "event");
			cmp_irq(1'b0);
			rd(6'h04, 16'h0000, "event clear");
			H.skip(kb[k]);
		end
		$display("kinds done");
		// Address filter failure
		wr(6'h05, 16'h0180);
		rx_start(64, 1'b0);
		rx_eof(1'b0);
		cmp_irq(1'b0);
		rd(6'h04, 16'h0000, "filtered");
		rd(6'h0c, 16'h0000, "filtered early");
		$display("filter done");
		// Early address flag, then sequential read with the check sequence kept
		wr(6'h03, 16'h0900);
		rx_start(6, 1'b1);
		rd(6'h0c, 16'h8000, "addr flag");
		rx_bytes(58, 1'b1);
		rx_eof(1'b0);
		rd(6'h04, 16'h0100, "held");
		for (int i = 0; i < 32; i++) begin
			H.word(q);
			cmp(q, {8'(2 * i + 1), 8'(2 * i)}, "data");
		end
		$display("read done");
		// Committed frame blocks the next one, no early flags meanwhile
		wr(6'h0b, 16'h8c00);
		frame(64);
		cmp_irq(1'b1);
		rd(6'h04, 16'h0100, "commit");
		rd(6'h0c, 16'h8000, "addr kept");
		frame(64);
		cmp_irq(1'b1);
		rd(6'h0c, 16'h0400, "lost");
		H.skip(16'h0900);
		// Partial commit after the block flag
		rx_start(130, 1'b1);
		cmp_irq(1'b1);
		rd(6'h0c, 16'h0800, "block flag");
		rx_eof(1'b0);
		rd(6'h04, 16'h0100, "partial");
		frame(64);
		rd(6'h0c, 16'h0400, "lost partial");
		H.skip(16'h0900);
		// End of frame clears the block flag
		rx_start(130, 1'b1);
		rx_eof(1'b0);
		rd(6'h0c, 16'h0000, "eof clear");
		rd(6'h04, 16'h0100, "eof event");
		H.skip(16'h0900);
		$display("commit done");
		// Frames moved by DMA
		wr(6'h0b, 16'h0080);
		@(posedge CLK) #1 DFD = 1'b1;
		@(posedge CLK) #1 DFD = 1'b0;
		cmp_irq(1'b1);
		rd(6'h0c, 16'h0080, "dma done");
		cmp_irq(1'b0);
		$display("dma done");
		// DMA routing: forced for every frame, then bus hold limit and abort
		wr(6'h17, 16'h0800);
		wr(6'h03, 16'h0200);
		dma_n = 0;
		rx_start(1520, 1'b1);
		rx_eof(1'b0);
		cmp(16'(dma_n), 16'h05ee, "dma bytes");
		cmp({8'h00, dma_last}, 16'h00ed, "dma last");
		cmp(16'(rel_n), 16'h0001, "bus release");
		rd(6'h04, 16'h4000, "dma event");
		rx_start(20, 1'b0);
		rx_eof(1'b0);
		cmp(16'(abort_n), 16'h0001, "dma abort");
		// Auto switch sends the next frame to DMA while one is committed
		wr(6'h03, 16'h0500);
		frame(64);
		rd(6'h04, 16'h0100, "auto held");
		dma_n = 0;
		frame(64);
		cmp(16'(dma_n), 16'h0040, "auto dma");
		rd(6'h0c, 16'h8000, "no loss");
		// Lost counter wraps on the 1024th loss; two frames were lost above
		wr(6'h03, 16'h0000);
		repeat (1021) begin
			rx_start(0, 1'b1);
			rx_eof(1'b0);
		end
		rd(6'h0c, 16'h0400, "no wrap yet");
		wr(6'h0b, 16'h2000);
		rx_start(0, 1'b1);
		rx_eof(1'b0);
		cmp_irq(1'b1);
		rd(6'h0c, 16'h2400, "wrap");
		// Event read of a later frame frees the held one
		rd(6'h04, 16'h0100, "later event");
		frame(64);
		rd(6'h0c, 16'h8000, "freed");
		$display("routing done");
		give_verdict();
	end
endmodule // tb_rx_frame_preprocess_buffer
